// File: verilog/ast_transmitter.sv
// Transmit side of the asynchronous serial interface with its baud generators.
//
// Notes on behaviour
// - Enabled and not sending, output pin high.
// - Both enables off releases the output pin.
// - Frame starts low bit, ends high bit.
// - Data bits go out least significant first.
// - Word length 8 or 9; ninth from control.
// - Idle frame is a whole frame of ones.
// - Break frames of zeros, then one mark bit.
// - Transmit and receive baud generators are independent.
// - Enabling transmitter sends one idle frame before any data frame.
// - Buffer-empty clears on status read, data write.
// - Buffer-empty sets when holding moves to shifter.
// - Buffer-empty with enable raises masked interrupt.
// - Write during frame waits in holding buffer.
// - Write while idle starts sending at once.
// - Data or break frame end sets complete flag, maybe interrupt.
// - Complete flag clears by the same sequence.
// - Breaks repeat while break control set.
// - Enable toggle mid-frame: idle frame, holding lost.
// - Bit rate is clock/(16*prescaler*divider*fine prescaler).
`timescale 1ns/1ns
`default_nettype none
`include "ast_defines.svh"
module ast_transmitter (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              txEnable,
    input  wire logic              rxEnable,
    input  wire logic              wordLen9,
    input  wire logic              txNinthBit,
    input  wire logic              sendBreakCtl,
    input  wire logic              txEmptyIrqEn,
    input  wire logic              txCompleteIrqEn,
    input  wire logic              cpuIrqMask,
    input  wire ast_pkg::ast_baud_s txBaud,
    input  wire ast_pkg::ast_baud_s rxBaud,
    input  wire logic              statusRead,
    input  wire logic              dataWrite,
    input  wire logic [7:0]        dataIn,
    output logic                   dataWriteReady,
    output ast_pkg::ast_flags_s    flags,
    output logic                   txIrq,
    output logic                   rxSampleTick,
    output logic                   serialTxOut,
    output logic                   serialTxOe
);
    import ast_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ast_txst_e  st;
        ast_kind_e  kind;
        logic [10:0] shift;
        logic [3:0] bitsLeft;
        logic [18:0] txDiv;
        logic [3:0] txSub;
        logic [18:0] rxDiv;
        logic [3:0] rxSub;
        logic       rxTick;
        ast_word_s  hold;
        logic       holdFull;
        logic       pendIdle;
        logic       enPrev;
        logic       armed;
        ast_flags_s flg;
        logic       line;
        logic       oe;
    } ast_state_s;

    ast_state_s s;
    ast_state_s next_s;
    ast_word_s  wrWord;
    ast_word_s  fifoWord;
    logic       fifoValid;
    logic       fifoPop;
    logic [18:0] txDivisor;
    logic [18:0] rxDivisor;
    logic       txBitEnd;
    logic       frameEnd;
    logic       pickNext;
    logic       emptyReq;
    logic       doneReq;

    // Cycles per oversampling tick: prescaler times power-of-two divider
    // times the fine prescaler, which counts as one when zero.
    function automatic logic [18:0] baudDivisor(input ast_baud_s b);
        logic [4:0]  pr;
        logic [7:0]  fine;
        logic [18:0] prod;
        unique case (b.presc)
            2'd0: pr = `AST_PRESC_0;
            2'd1: pr = `AST_PRESC_1;
            2'd2: pr = `AST_PRESC_2;
            2'd3: pr = `AST_PRESC_3;
        endcase
        fine = (b.fine == 8'h00) ? 8'h01 : b.fine;
        prod = 19'(pr) * 19'(fine);
        return 19'(prod << b.divSel);
    endfunction

    function automatic logic [3:0] frameBits(input logic nine);
        return nine ? `AST_FRAME_BITS_9 : `AST_FRAME_BITS_8;
    endfunction

    // Start low, data least significant bit first, ninth bit if any, stop high.
    function automatic logic [10:0] dataFrame(input ast_word_s wd, input logic nine);
        if (nine) begin
            return {1'b1, wd.ninth, wd.low, 1'b0};
        end
        return {2'b11, wd.low, 1'b0};
    endfunction

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if ($bits(ast_word_s) != `AST_WORD_WIDTH) begin : g_bad_word
        $error("ast_transmitter: word struct and word width disagree");
    end
    if (`AST_FRAME_BITS_9 > 11 || `AST_FRAME_BITS_8 > `AST_FRAME_BITS_9) begin : g_bad_frame
        $error("ast_transmitter: frame longer than the shift register");
    end

    // ------------------------------------------------------------
    // Write queue
    // ------------------------------------------------------------
    assign wrWord.ninth = txNinthBit;
    assign wrWord.low   = dataIn;
    assign fifoPop      = fifoValid && !s.holdFull && txEnable;

    ast_fifo #(
        .WIDTH ($bits(ast_word_s)),
        .DEPTH (`AST_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (dataWrite),
        .inData   (wrWord),
        .inReady  (dataWriteReady),
        .outValid (fifoValid),
        .outData  (fifoWord),
        .outReady (fifoPop)
    );

    // ------------------------------------------------------------
    // Baud timing
    // ------------------------------------------------------------
    assign txDivisor = baudDivisor(txBaud);
    assign rxDivisor = baudDivisor(rxBaud);
    assign txBitEnd  = (s.st != TX_IDLE) && (s.txDiv == txDivisor - 19'd1)
                       && (s.txSub == 4'(`AST_OVERSAMPLE - 1));
    assign frameEnd  = txBitEnd && (s.bitsLeft == 4'd1);
    assign pickNext  = (s.st == TX_IDLE) || frameEnd;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.enPrev = txEnable;
        next_s.rxTick = 1'b0;

        // --------------------------------------------------------
        // Transmit bit timer runs only while a frame is on the line.
        // --------------------------------------------------------
        if (s.st == TX_IDLE) begin
            next_s.txDiv = '0;
            next_s.txSub = '0;
        end else if (s.txDiv == txDivisor - 19'd1) begin
            next_s.txDiv = '0;
            next_s.txSub = s.txSub + 4'd1;
        end else begin
            next_s.txDiv = s.txDiv + 19'd1;
        end

        // --------------------------------------------------------
        // Receive tick generator, separate divider and enable.
        // --------------------------------------------------------
        if (!rxEnable) begin
            next_s.rxDiv = '0;
            next_s.rxSub = '0;
        end else if (s.rxDiv == rxDivisor - 19'd1) begin
            next_s.rxDiv  = '0;
            next_s.rxSub  = s.rxSub + 4'd1;
            next_s.rxTick = 1'b1;
        end else begin
            next_s.rxDiv = s.rxDiv + 19'd1;
        end

        // --------------------------------------------------------
        // Software flag sequence: a status read arms, a data write clears.
        // --------------------------------------------------------
        if (statusRead) begin
            next_s.armed = 1'b1;
        end
        if (dataWrite && dataWriteReady && s.armed) begin
            next_s.flg.bufEmpty = 1'b0;
            next_s.flg.complete = 1'b0;
            next_s.armed        = 1'b0;
        end

        // --------------------------------------------------------
        // Queue to holding buffer; holding is lost when disabled.
        // --------------------------------------------------------
        if (fifoPop) begin
            next_s.hold     = fifoWord;
            next_s.holdFull = 1'b1;
        end
        if (!txEnable) begin
            next_s.holdFull = 1'b0;
        end
        if (txEnable && !s.enPrev) begin
            next_s.pendIdle = 1'b1;
        end

        // --------------------------------------------------------
        // Shift out one bit at each bit end.
        // --------------------------------------------------------
        if (txBitEnd) begin
            next_s.shift    = {1'b1, s.shift[10:1]};
            next_s.bitsLeft = s.bitsLeft - 4'd1;
        end

        // --------------------------------------------------------
        // Completion of a data or break frame.
        // --------------------------------------------------------
        if (frameEnd && s.st == TX_FRAME && s.kind != FK_IDLE) begin
            next_s.flg.complete = 1'b1;
        end

        // --------------------------------------------------------
        // Choose what goes on the line next.
        // --------------------------------------------------------
        if (pickNext) begin
            if (frameEnd && s.st == TX_FRAME && s.kind == FK_BREAK && !sendBreakCtl) begin
                next_s.st       = TX_MARK;
                next_s.shift    = '1;
                next_s.bitsLeft = 4'd1;
            end else if (txEnable && sendBreakCtl) begin
                next_s.st       = TX_FRAME;
                next_s.kind     = FK_BREAK;
                next_s.shift    = '0;
                next_s.bitsLeft = frameBits(wordLen9);
            end else if (txEnable && (s.pendIdle || next_s.pendIdle)) begin
                next_s.st       = TX_FRAME;
                next_s.kind     = FK_IDLE;
                next_s.shift    = '1;
                next_s.bitsLeft = frameBits(wordLen9);
                next_s.pendIdle = 1'b0;
            end else if (txEnable && s.holdFull) begin
                next_s.st       = TX_FRAME;
                next_s.kind     = FK_DATA;
                next_s.bitsLeft = frameBits(wordLen9);
                next_s.holdFull = 1'b0;
                next_s.flg.bufEmpty = 1'b1;
                next_s.shift = dataFrame(s.hold, wordLen9);
            end else begin
                next_s.st = TX_IDLE;
            end
        end

        // --------------------------------------------------------
        // Pin: high whenever no frame bit is being sent.
        // --------------------------------------------------------
        if (next_s.st == TX_IDLE) begin
            next_s.line = `AST_LINE_IDLE;
        end else begin
            next_s.line = next_s.shift[0];
        end
        next_s.oe = txEnable || rxEnable;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s              <= '0;
            s.st           <= TX_IDLE;
            s.kind         <= FK_DATA;
            s.flg.bufEmpty <= `AST_BUF_EMPTY_RST;
            s.flg.complete <= `AST_COMPLETE_RST;
            s.line         <= `AST_LINE_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign flags        = s.flg;
    assign serialTxOut  = s.line;
    assign serialTxOe   = s.oe;
    assign rxSampleTick = s.rxTick;
    assign emptyReq     = s.flg.bufEmpty && txEmptyIrqEn;
    assign doneReq      = s.flg.complete && txCompleteIrqEn;
    assign txIrq        = !cpuIrqMask && (emptyReq || doneReq);
endmodule // ast_transmitter
`default_nettype wire

// File: verilog/ast_defines.svh
// Constants for the asynchronous serial transmitter.
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH
`define AST_OVERSAMPLE     16
`define AST_PRESC_0        5'd1
`define AST_PRESC_1        5'd3
`define AST_PRESC_2        5'd4
`define AST_PRESC_3        5'd13
`define AST_FRAME_BITS_8   4'd10
`define AST_FRAME_BITS_9   4'd11
`define AST_FIFO_DEPTH     8
`define AST_WORD_WIDTH     9
`define AST_BUF_EMPTY_RST  1'b1
`define AST_COMPLETE_RST   1'b1
`define AST_LINE_IDLE      1'b1
`endif

// File: verilog/ast_pkg.sv
// Types shared by the asynchronous serial transmitter files.
package ast_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_MARK} ast_txst_e;
    typedef enum logic [1:0] {FK_DATA, FK_IDLE, FK_BREAK} ast_kind_e;
    typedef struct packed {
        logic       ninth;
        logic [7:0] low;
    } ast_word_s;
    typedef struct packed {
        logic [1:0] presc;
        logic [2:0] divSel;
        logic [7:0] fine;
    } ast_baud_s;
    typedef struct packed {
        logic bufEmpty;
        logic complete;
    } ast_flags_s;
endpackage

// File: verilog/ast_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
`include "ast_defines.svh"
module ast_fifo #(
    parameter int WIDTH = `AST_WORD_WIDTH,
    parameter int DEPTH = `AST_FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    import ast_pkg::*;
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("ast_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } fifo_state_s;

    fifo_state_s s;
    fifo_state_s next_s;
    logic        full;
    logic        empty;

    assign full     = (s.wp ^ s.rp) == {1'b1, {AW{1'b0}}};
    assign empty    = s.wp == s.rp;
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = s.mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (inValid && !full) begin
            next_s.mem[s.wp[AW-1:0]] = inData;
            next_s.wp = s.wp + 1'b1;
        end
        if (outReady && !empty) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // ast_fifo
`default_nettype wire

// File: verif/ast_tx_checker.sv
// Port assertions for the serial transmitter.
`timescale 1ns/1ns
`default_nettype none
module ast_tx_checker import ast_pkg::*; (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              txEnable,
    input wire logic              rxEnable,
    input wire logic              txEmptyIrqEn,
    input wire logic              txCompleteIrqEn,
    input wire logic              cpuIrqMask,
    input wire logic              dataWrite,
    input wire logic              dataWriteReady,
    input wire ast_pkg::ast_flags_s flags,
    input wire logic              txIrq,
    input wire logic              rxSampleTick,
    input wire logic              serialTxOut,
    input wire logic              serialTxOe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // A bit lasts at least sixteen clocks at the smallest divisor.
    sequence bitLow;
        (!serialTxOut)[*8] ##1 (!serialTxOut)[*8];
    endsequence
    sequence bitHigh;
        serialTxOut[*8] ##1 serialTxOut[*8];
    endsequence
    pin_own_a: assert property ((txEnable || rxEnable) |=> serialTxOe)
        else $error("pin not owned");
    pin_free_a: assert property (!(txEnable || rxEnable) |=> !serialTxOe)
        else $error("pin not released");
    irq_mix_a: assert property (txIrq == (!cpuIrqMask && ((flags.bufEmpty && txEmptyIrqEn)
        || (flags.complete && txCompleteIrqEn)))) else $error("irq mismatch");
    low_bit_a: assert property ($fell(serialTxOut) |-> bitLow)
        else $error("short low bit");
    high_bit_a: assert property ($rose(serialTxOut) |-> bitHigh)
        else $error("short high bit");
    empty_clear_a: assert property ($fell(flags.bufEmpty) |-> $past(dataWrite && dataWriteReady))
        else $error("empty cleared without write");
    done_clear_a: assert property ($fell(flags.complete) |-> $past(dataWrite && dataWriteReady))
        else $error("complete cleared without write");
    empty_set_a: assert property ($rose(flags.bufEmpty) && $past(txEnable) && txEnable
        |-> !serialTxOut) else $error("empty set without start");
    tick_pulse_a: assert property (rxSampleTick |=> !rxSampleTick)
        else $error("tick too long");
    tick_off_a: assert property (!rxEnable |=> !rxSampleTick)
        else $error("tick while off");
endmodule // ast_tx_checker
bind ast_transmitter ast_tx_checker chk_u (.ref_clk, .rst, .txEnable, .rxEnable, .txEmptyIrqEn,
    .txCompleteIrqEn, .cpuIrqMask, .dataWrite, .dataWriteReady, .flags, .txIrq, .rxSampleTick,
    .serialTxOut, .serialTxOe);
`default_nettype wire

// File: verif/ast_line_model.sv
// Receiving equipment model that decodes frames off the line.
`timescale 1ns/1ns
`default_nettype none
module ast_line_model #(
    parameter int BIT = 16
) (
    input  wire logic       ref_clk,
    input  wire logic       line,
    input  wire logic       wordLen9,
    output logic            frameValid,
    output logic [8:0]      frameWord,
    output logic            frameBreak
);
    int         i;
    logic [8:0] w;
    initial begin
        frameValid = 1'b0;
        frameWord = '0;
        frameBreak = 1'b0;
        forever begin
            do @(posedge ref_clk); while (line !== 1'b1);
            do @(posedge ref_clk); while (line !== 1'b0);
            repeat (BIT / 2) @(posedge ref_clk);
            w = '0;
            for (i = 0; i < (wordLen9 ? 9 : 8); i++) begin
                repeat (BIT) @(posedge ref_clk);
                w[i] = line;
            end
            repeat (BIT) @(posedge ref_clk);
            frameWord <= w;
            frameBreak <= (w == 9'h000) && (line !== 1'b1);
            frameValid <= 1'b1;
            @(posedge ref_clk);
            frameValid <= 1'b0;
        end
    end
endmodule // ast_line_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the serial transmitter.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import ast_pkg::*;
    logic ref_clk, rst, txEnable, rxEnable, wordLen9, txNinthBit, sendBreakCtl, statusRead;
    logic txEmptyIrqEn, txCompleteIrqEn, cpuIrqMask, dataWrite, dataWriteReady, txIrq;
    logic rxSampleTick, serialTxOut, serialTxOe, frameValid, frameBreak, ok, irqExp;
    logic [7:0] dataIn;
    logic [8:0] frameWord, w;
    ast_baud_s  txBaud, rxBaud;
    ast_flags_s flags;
    logic [8:0] expQ[$];
    int         errors, total_checks, breaks, seed, n, m;
    wire pinLevel = serialTxOe ? serialTxOut : 1'b1;
    ast_transmitter dut_u (.ref_clk, .rst, .txEnable, .rxEnable, .wordLen9, .txNinthBit,
        .sendBreakCtl, .txEmptyIrqEn, .txCompleteIrqEn, .cpuIrqMask, .txBaud, .rxBaud,
        .statusRead, .dataWrite, .dataIn, .dataWriteReady, .flags, .txIrq, .rxSampleTick,
        .serialTxOut, .serialTxOe);
    ast_line_model line_u (.ref_clk, .line(pinLevel), .wordLen9, .frameValid, .frameWord,
        .frameBreak);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) if (!rst) {txEmptyIrqEn, txCompleteIrqEn, cpuIrqMask} <= 3'($random(seed));
    always @(negedge ref_clk) if (!rst) begin
        irqExp = (flags.bufEmpty && txEmptyIrqEn) || (flags.complete && txCompleteIrqEn);
        `CHK("irq", irqExp && !cpuIrqMask, txIrq)
    end
    always @(posedge ref_clk) if (frameValid === 1'b1) begin
        if (frameBreak) breaks++;
        else begin
            w = (expQ.size() != 0) ? expQ.pop_front() : 9'h1ff;
            `CHK("word", w, frameWord)
        end
    end
    task automatic wr(input logic [8:0] v);
        @(negedge ref_clk);
        dataWrite = 1'b1;
        {txNinthBit, dataIn} = v;
        do @(posedge ref_clk); while (dataWriteReady !== 1'b1);
        expQ.push_back(wordLen9 ? v : {1'b0, v[7:0]});
    endtask
    task automatic wend();
        @(negedge ref_clk);
        dataWrite = 1'b0;
    endtask
    task automatic sr();
        @(negedge ref_clk);
        statusRead = 1'b1;
        @(negedge ref_clk);
        statusRead = 1'b0;
    endtask
    task automatic drain();
        for (int k = 0; k < 20000 && expQ.size() != 0; k++) @(posedge ref_clk);
        repeat (40) @(posedge ref_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        end_sim();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 34204;
        {errors, total_checks, breaks} = '0;
        {rst, txEnable, rxEnable, wordLen9, txNinthBit, sendBreakCtl, statusRead} = 7'h01 << 6;
        {txEmptyIrqEn, txCompleteIrqEn, cpuIrqMask, dataWrite, dataIn} = '0;
        txBaud = '0;
        rxBaud = 13'h0900;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        `CHK("rstFlags", 2'b11, flags)
        `CHK("rstOe", 1'b0, serialTxOe)
        `CHK("rstLine", 1'b1, serialTxOut)
        rxEnable = 1'b1;
        while (rxSampleTick !== 1'b1) @(posedge ref_clk);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (rxSampleTick !== 1'b1);
        `CHK("tickGap", 6, n)
        @(negedge ref_clk) txEnable = 1'b1;
        n = 0;
        fork
            begin wr(9'($random(seed))); wend(); end
            while (serialTxOut !== 1'b0) begin @(posedge ref_clk); n++; end
        join
        `CHK("idleGap", 1'b1, n >= 160 && n <= 175)
        drain();
        sr();
        wr(9'($random(seed)));
        wend();
        `CHK("seqClear", 2'b00, flags)
        repeat (5) @(negedge ref_clk);
        `CHK("directLoad", 2'b10, flags)
        wr(9'($random(seed)));
        wend();
        `CHK("noArm", 2'b10, flags)
        sr();
        wr(9'($random(seed)));
        wend();
        repeat (20) @(negedge ref_clk);
        `CHK("holding", 2'b00, flags)
        drain();
        `CHK("doneFlags", 2'b11, flags)
        for (m = 0; m < 2; m++) begin
            @(negedge ref_clk) wordLen9 = m[0];
            repeat (4) wr(9'($random(seed)));
            wend();
            drain();
        end
        @(negedge ref_clk) sendBreakCtl = 1'b1;
        repeat (20) @(posedge ref_clk);
        n = 0;
        do begin
            @(negedge ref_clk);
            dataWrite = 1'b1;
            {txNinthBit, dataIn} = 9'($random(seed));
            @(posedge ref_clk);
            ok = (dataWriteReady === 1'b1);
            if (ok) begin expQ.push_back({txNinthBit, dataIn}); n++; end
        end while (ok && n < 12);
        wend();
        `CHK("fillCount", 9, n)
        repeat (200) @(posedge ref_clk);
        @(negedge ref_clk) sendBreakCtl = 1'b0;
        drain();
        `CHK("breakSeen", 1'b1, breaks > 0)
        `CHK("leftover", 0, expQ.size())
        @(negedge ref_clk) {txEnable, rxEnable} = 2'b00;
        repeat (3) @(negedge ref_clk);
        `CHK("release", 1'b0, serialTxOe)
        `CHK("idleLine", 1'b1, serialTxOut)
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
